/* rtl/sfc_defs.svh */
// register map, field positions and reset values of the split frame cropper
// assumes byte-wide registers reached over a plain strobe port
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define SFC_OFS_HSTART_LOW  8'h36
`define SFC_OFS_EN_HSTART_HI 8'h37
`define SFC_OFS_HSTOP_LOW   8'h38
`define SFC_OFS_HSTOP_HIGH  8'h39
`define SFC_OFS_VSTART_LOW  8'h3A
`define SFC_OFS_VSTART_HIGH 8'h3B
`define SFC_OFS_VSTOP_LOW   8'h3C
`define SFC_OFS_VSTOP_HIGH  8'h3D
`define SFC_OFS_PORT_SEL    8'h40
`define SFC_OFS_STATUS      8'h41

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define SFC_ENABLE_BIT  7
`define SFC_HIGH_MSB    4
`define SFC_SEL_BIT     0

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define SFC_RST_COORD   13'h0000
`define SFC_RST_ENABLE  1'b0
`define SFC_RST_SEL     1'b0

`endif

/* rtl/sfc_pkg.sv */
// shared types of the split frame cropper
// assumes 13-bit crop coordinates and byte registers
package sfc_pkg;
  typedef logic [12:0] sfc_coord_t;
  typedef logic [7:0] sfc_byte_t;
endpackage

/* rtl/sfc_port_crop.sv */
// per-port crop stage: counts pixel and line position and blanks outside
// assumes a pixel strobe at the port rate and an active-high vsync
`timescale 1ns/1ps
`include "sfc_defs.svh"

module sfc_port_crop #(
  parameter int DW = 24
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic stb_i,
  input wire logic [DW-1:0] data_i,
  input wire logic active_video_flag_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic crop_en_i,
  input wire sfc_pkg::sfc_coord_t hstart_i,
  input wire sfc_pkg::sfc_coord_t hstop_i,
  input wire sfc_pkg::sfc_coord_t vstart_i,
  input wire sfc_pkg::sfc_coord_t vstop_i,
  output logic [DW-1:0] data_o,
  output logic active_video_flag_o,
  output logic hsync_o,
  output logic vsync_o
);

  typedef struct packed {
    sfc_pkg::sfc_coord_t x;
    sfc_pkg::sfc_coord_t y;
    logic de_d;
    logic [DW-1:0] data;
    logic de;
    logic hs;
    logic vs;
  } sfc_crop_s;

  sfc_crop_s st;
  sfc_crop_s next_st;
  logic keep;

  // --------------------------------------------------------------------
  // window test and counters
  // --------------------------------------------------------------------
  always_comb begin
    // x and y are the position of the pixel now on the input
    keep = !crop_en_i ||
      ((st.x >= hstart_i) && (st.x <= hstop_i) &&
       (st.y >= vstart_i) && (st.y <= vstop_i));
    next_st = st;
    if (stb_i) begin
      // origin is the first active pixel of the first active line
      next_st.x = active_video_flag_i ? sfc_pkg::sfc_coord_t'(st.x + 13'h0001) : 13'h0000;
      if (vsync_i) begin
        next_st.y = 13'h0000;
      end else if (st.de_d && !active_video_flag_i) begin
        next_st.y = sfc_pkg::sfc_coord_t'(st.y + 13'h0001);
      end
      next_st.de_d = active_video_flag_i;
      next_st.de = active_video_flag_i && keep;
      next_st.data = (active_video_flag_i && keep) ? data_i : '0;
      // syncs pass untouched, so removed pixels simply widen blanking
      next_st.hs = hsync_i;
      next_st.vs = vsync_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_o = st.data;
  assign active_video_flag_o = st.de;
  assign hsync_o = st.hs;
  assign vsync_o = st.vs;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_before_hstart;
    @(posedge core_clk_i) disable iff (rst_i)
    stb_i && crop_en_i && active_video_flag_i && (st.x < hstart_i) |=> !active_video_flag_o;
  endproperty
  a_before_hstart: assert property (p_before_hstart) else $error("pixel before start forwarded");

  property p_after_hstop;
    @(posedge core_clk_i) disable iff (rst_i)
    stb_i && crop_en_i && (st.x > hstop_i) |=> !active_video_flag_o && (data_o == '0);
  endproperty
  a_after_hstop: assert property (p_after_hstop) else $error("pixel after stop forwarded");

  property p_vwindow;
    @(posedge core_clk_i) disable iff (rst_i)
    stb_i && crop_en_i && ((st.y < vstart_i) || (st.y > vstop_i)) |=> !active_video_flag_o;
  endproperty
  a_vwindow: assert property (p_vwindow) else $error("line outside window forwarded");

  property p_bypass;
    @(posedge core_clk_i) disable iff (rst_i)
    stb_i && !crop_en_i |=> (active_video_flag_o == $past(active_video_flag_i)) &&
      (!active_video_flag_o || (data_o == $past(data_i)));
  endproperty
  a_bypass: assert property (p_bypass) else $error("disabled crop altered video");

  property p_sync_kept;
    @(posedge core_clk_i) disable iff (rst_i)
    stb_i |=> (hsync_o == $past(hsync_i)) && (vsync_o == $past(vsync_i));
  endproperty
  a_sync_kept: assert property (p_sync_kept) else $error("sync timing changed");

  property p_origin;
    @(posedge core_clk_i) disable iff (rst_i)
    stb_i && !active_video_flag_i |=> (st.x == 13'h0000);
  endproperty
  a_origin: assert property (p_origin) else $error("pixel index not reset in blanking");

endmodule // sfc_port_crop

/* rtl/sfc_top.sv */
// split frame cropper: splits an alternate-pixel superframe into two
// half-rate streams and crops each to its own programmed rectangle
// assumes the superframe arrives already in alternate-pixel order,
// one pixel per clock, with active-high syncs
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "sfc_defs.svh"

// Functional notes
// - each split image may be cropped so each output carries a smaller resolution
// - each output runs at half the superframe pixel rate, cropping or not
// - cropped pixels and lines lengthen blanking, line and frame timing kept
// - superframe is split into alternate-pixel images first, then cropped
// - crop coordinates count from first pixel of first active line
// - crop settings per port; crop register access hits only the selected port
// - enable register bit 7 turns cropping on, resets to zero
// - 13-bit horizontal start: low byte register, upper five bits in enable register
// - pixels before horizontal start are blanked with data-enable low
// - horizontal stop names last forwarded pixel, low byte in own register
// - pixels after horizontal stop are blanked with data-enable low
// - horizontal positions are zero-based, up to line length minus one
// - horizontal stop bits 12:8 in next register bits 4:0, 7:5 read zero
// - vertical start names first forwarded line, earlier lines blanked
module sfc_top #(
  parameter int DW = 24,
  parameter int NPORT = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [DW-1:0] sf_data_i,
  input wire logic sf_active_video_flag_i,
  input wire logic sf_hsync_i,
  input wire logic sf_vsync_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic pix_stb_o,
  output logic [DW-1:0] p0_data_o,
  output logic p0_active_video_flag_o,
  output logic p0_hsync_o,
  output logic p0_vsync_o,
  output logic [DW-1:0] p1_data_o,
  output logic p1_active_video_flag_o,
  output logic p1_hsync_o,
  output logic p1_vsync_o
);

  typedef struct packed {
    logic [NPORT-1:0] crop_en;
    logic [NPORT-1:0][12:0] hstart;
    logic [NPORT-1:0][12:0] hstop;
    logic [NPORT-1:0][12:0] vstart;
    logic [NPORT-1:0][12:0] vstop;
    logic sel;
    logic [7:0] rdata;
    logic phase;
    logic prev_de;
    logic [DW-1:0] even_data;
    logic split_stb;
    logic [NPORT-1:0][DW-1:0] pdata;
    logic de_pair;
    logic hs_pair;
    logic vs_pair;
    logic stb_out;
  } sfc_top_s;

  sfc_top_s st;
  sfc_top_s next_st;

  logic [NPORT-1:0][DW-1:0] crop_data;
  logic [NPORT-1:0] crop_de;
  logic [NPORT-1:0] crop_hs;
  logic [NPORT-1:0] crop_vs;

  // high byte of a coordinate, reserved bits above it read zero
  function automatic logic [7:0] hi_byte(input logic [12:0] v);
    hi_byte = {3'h0, v[12:8]};
  endfunction

  // --------------------------------------------------------------------
  // registers, split and pairing
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;

    // writes land only in the port named by the select register
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `SFC_OFS_HSTART_LOW: next_st.hstart[st.sel][7:0] = reg_wdata_i;
        `SFC_OFS_EN_HSTART_HI: begin
          next_st.crop_en[st.sel] = reg_wdata_i[`SFC_ENABLE_BIT];
          next_st.hstart[st.sel][12:8] = reg_wdata_i[`SFC_HIGH_MSB:0];
        end
        `SFC_OFS_HSTOP_LOW: next_st.hstop[st.sel][7:0] = reg_wdata_i;
        `SFC_OFS_HSTOP_HIGH: next_st.hstop[st.sel][12:8] = reg_wdata_i[`SFC_HIGH_MSB:0];
        `SFC_OFS_VSTART_LOW: next_st.vstart[st.sel][7:0] = reg_wdata_i;
        `SFC_OFS_VSTART_HIGH: next_st.vstart[st.sel][12:8] = reg_wdata_i[`SFC_HIGH_MSB:0];
        `SFC_OFS_VSTOP_LOW: next_st.vstop[st.sel][7:0] = reg_wdata_i;
        `SFC_OFS_VSTOP_HIGH: next_st.vstop[st.sel][12:8] = reg_wdata_i[`SFC_HIGH_MSB:0];
        `SFC_OFS_PORT_SEL: next_st.sel = reg_wdata_i[`SFC_SEL_BIT];
        default: begin
        end
      endcase
    end

    // unmapped reads return zero
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `SFC_OFS_HSTART_LOW: next_st.rdata = st.hstart[st.sel][7:0];
        `SFC_OFS_EN_HSTART_HI: next_st.rdata = {st.crop_en[st.sel], 2'h0, st.hstart[st.sel][12:8]};
        `SFC_OFS_HSTOP_LOW: next_st.rdata = st.hstop[st.sel][7:0];
        `SFC_OFS_HSTOP_HIGH: next_st.rdata = hi_byte(st.hstop[st.sel]);
        `SFC_OFS_VSTART_LOW: next_st.rdata = st.vstart[st.sel][7:0];
        `SFC_OFS_VSTART_HIGH: next_st.rdata = hi_byte(st.vstart[st.sel]);
        `SFC_OFS_VSTOP_LOW: next_st.rdata = st.vstop[st.sel][7:0];
        `SFC_OFS_VSTOP_HIGH: next_st.rdata = hi_byte(st.vstop[st.sel]);
        `SFC_OFS_PORT_SEL: next_st.rdata = {7'h00, st.sel};
        `SFC_OFS_STATUS: next_st.rdata = {6'h00, crop_de[1], crop_de[0]};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // phase realigns at each line start so the first active pixel is even;
    // an odd-length line would otherwise swap the two images mid-frame
    next_st.prev_de = sf_active_video_flag_i;
    if (sf_active_video_flag_i && !st.prev_de) begin
      // first active pixel of the line is even: hold it for the pair
      next_st.phase = 1'b0;
    end else begin
      next_st.phase = !st.phase;
    end
    next_st.split_stb = 1'b0;
    if (!next_st.phase) begin
      next_st.even_data = sf_data_i;
    end else begin
      // even pixel to port 0, odd pixel to port 1, one pair per two clocks
      next_st.pdata[0] = st.even_data;
      next_st.pdata[1] = sf_data_i;
      next_st.de_pair = sf_active_video_flag_i;
      next_st.hs_pair = sf_hsync_i;
      next_st.vs_pair = sf_vsync_i;
      next_st.split_stb = 1'b1;
    end
    next_st.stb_out = st.split_stb;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // per-port crop stages
  // --------------------------------------------------------------------
  for (genvar gp = 0; gp < NPORT; gp++) begin : g_port
    sfc_port_crop #(
      .DW(DW)
    ) u_crop (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .stb_i(st.split_stb),
      .data_i(st.pdata[gp]),
      .active_video_flag_i(st.de_pair),
      .hsync_i(st.hs_pair),
      .vsync_i(st.vs_pair),
      .crop_en_i(st.crop_en[gp]),
      .hstart_i(st.hstart[gp]),
      .hstop_i(st.hstop[gp]),
      .vstart_i(st.vstart[gp]),
      .vstop_i(st.vstop[gp]),
      .data_o(crop_data[gp]),
      .active_video_flag_o(crop_de[gp]),
      .hsync_o(crop_hs[gp]),
      .vsync_o(crop_vs[gp])
    );
  end

  assign reg_rdata_o = st.rdata;
  assign pix_stb_o = st.stb_out;
  assign p0_data_o = crop_data[0];
  assign p0_active_video_flag_o = crop_de[0];
  assign p0_hsync_o = crop_hs[0];
  assign p0_vsync_o = crop_vs[0];
  assign p1_data_o = crop_data[1];
  assign p1_active_video_flag_o = crop_de[1];
  assign p1_hsync_o = crop_hs[1];
  assign p1_vsync_o = crop_vs[1];

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_half_rate;
    @(posedge core_clk_i) disable iff (rst_i)
    pix_stb_o && !(sf_active_video_flag_i && !st.prev_de) |=> !pix_stb_o;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("output strobe above half rate");

  property p_enable_write;
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && (reg_addr_i == `SFC_OFS_EN_HSTART_HI) |=>
      (st.crop_en[$past(st.sel)] == $past(reg_wdata_i[7])) &&
      (st.hstart[$past(st.sel)][12:8] == $past(reg_wdata_i[4:0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

  property p_port_isolation;
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && !st.sel |=> $stable(st.hstart[1]) && $stable(st.hstop[1]) && $stable(st.crop_en[1]);
  endproperty
  a_port_isolation: assert property (p_port_isolation) else $error("write hit unselected port");

  property p_reserved_zero;
    @(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && (reg_addr_i == `SFC_OFS_HSTOP_HIGH) |=>
      (reg_rdata_o == {3'h0, st.hstop[st.sel][12:8]});
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("stop high read wrong");

endmodule // sfc_top

/* dv/sfc_video_src.sv */
// behavioural host video source: alternate-pixel superframe, two equal images
// assumes one pixel per core clock; syncs active high
`timescale 1ns/1ps

module sfc_video_src #(
  parameter int DW = 24,
  parameter int W = 16,
  parameter int H = 6,
  parameter int HB = 8,
  parameter int VB = 3
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic [DW-1:0] data_o,
  output logic active_video_flag_o,
  output logic hsync_o,
  output logic vsync_o
);
  // ------------------------------------------------------------------
  // line and frame timing
  // ------------------------------------------------------------------
  int hc;
  int vc;
  logic act;
  // even width keeps both split images the same size
  assign act = (vc < H) && (hc < W);
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      hc <= 0;
      vc <= 0;
      data_o <= '0;
      active_video_flag_o <= 1'b0;
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
    end else begin
      hc <= (hc == W + HB - 1) ? 0 : hc + 1;
      if (hc == W + HB - 1) begin
        vc <= (vc == H + VB - 1) ? 0 : vc + 1;
      end
      // pixel carries its own line and column so the bench can place it
      // blank data is the inverse of the last value, never a stale copy
      data_o <= act ? DW'({8'(vc), 8'(hc)}) : ~data_o;
      active_video_flag_o <= act;
      // sync sits early in the porch: two-pixel front porch, four-pixel back porch
      hsync_o <= (hc >= W + 2) && (hc < W + 4);
      vsync_o <= (vc == H + 1);
    end
  end
endmodule // sfc_video_src

/* dv/tb_sfc_top.sv */
// self-checking bench of the split frame cropper
// assumes sfc_video_src as the host side; ports observed at pix_stb_o
`timescale 1ns/1ps

module tb_sfc_top;
  localparam int DW = 24;
  localparam int W = 16;
  localparam int H = 6;
  localparam int FRAME = (W + 8) * (H + 3);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic stb;
  logic [DW-1:0] s_data, d0, d1;
  logic s_f, s_h, s_v, f0, f1, h0, h1, v0, v1;
  int n_hs;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_fwd[2];
  int n_stb;
  logic en[2];
  logic [12:0] hs[2], he[2], vs[2], ve[2];

  always #5 clk = ~clk;

  sfc_video_src #(.DW(DW), .W(W), .H(H)) i_sfc_video_src (.core_clk_i(clk), .rst_i(rst),
    .data_o(s_data), .active_video_flag_o(s_f), .hsync_o(s_h), .vsync_o(s_v));

  sfc_top #(.DW(DW), .NPORT(2)) i_sfc_top (.core_clk_i(clk), .rst_i(rst),
    .sf_data_i(s_data), .sf_active_video_flag_i(s_f), .sf_hsync_i(s_h), .sf_vsync_i(s_v),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pix_stb_o(stb), .p0_data_o(d0), .p0_active_video_flag_o(f0), .p0_hsync_o(h0),
    .p0_vsync_o(v0), .p1_data_o(d1), .p1_active_video_flag_o(f1), .p1_hsync_o(h1),
    .p1_vsync_o(v1));

  // ------------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // a hang counts as a mismatch; the whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // output monitor: forwarded pixels must come from their own image and lie inside the box
  // ------------------------------------------------------------------
  task automatic mon(input int p, input logic f, input logic [DW-1:0] d);
    int x;
    int y;
    x = int'(d[7:0]) >> 1;
    y = int'(d[15:8]);
    if (f === 1'b1) begin
      n_fwd[p]++;
      check_val({31'b0, d[0]}, p);
      check_val({31'b0, en[p] && (x < hs[p] || x > he[p] || y < vs[p] || y > ve[p])}, 0);
    end else begin
      check_val({8'b0, d}, 0);
    end
  endtask

  always @(posedge clk) begin
    if (!rst && stb === 1'b1) begin
      n_stb++;
      if (h0 === 1'b1) begin
        n_hs++;
      end
      check_val({30'b0, h1, v1}, {30'b0, h0, v0});
      mon(0, f0, d0);
      mon(1, f1, d1);
    end
  end

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check_val({24'b0, rdata}, {24'b0, e});
  endtask

  task automatic set_crop(input int p, input logic e, input logic [12:0] a, b, c, d);
    wr_reg(8'h40, 8'(p));
    wr_reg(8'h36, a[7:0]);
    wr_reg(8'h37, {e, 2'b00, a[12:8]});
    wr_reg(8'h38, b[7:0]);
    wr_reg(8'h39, {3'b000, b[12:8]});
    wr_reg(8'h3A, c[7:0]);
    wr_reg(8'h3B, {3'b000, c[12:8]});
    wr_reg(8'h3C, d[7:0]);
    wr_reg(8'h3D, {3'b000, d[12:8]});
    en[p] = e;
    hs[p] = a;
    he[p] = b;
    vs[p] = c;
    ve[p] = d;
  endtask

  // counts over one whole frame that started under the current settings
  task automatic run_frame(input int e0, input int e1);
    @(posedge s_v);
    n_fwd = '{0, 0};
    n_stb = 0;
    n_hs = 0;
    @(posedge s_v);
    check_val(n_hs, H + 3);
    check_val(n_fwd[0], e0);
    check_val(n_fwd[1], e1);
    check_val(n_stb, FRAME / 2);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    for (int a = 8'h36; a <= 8'h39; a++) begin
      rd_chk(8'(a), 8'h00);
    end
    rd_chk(8'h50, 8'h00);
    wr_reg(8'h50, 8'hFF);
    rd_chk(8'h50, 8'h00);
    wr_reg(8'h37, 8'hFF);
    rd_chk(8'h37, 8'h9F);
    wr_reg(8'h39, 8'hFF);
    rd_chk(8'h39, 8'h1F);
    wr_reg(8'h38, 8'hA5);
    rd_chk(8'h38, 8'hA5);
    wr_reg(8'h3D, 8'hFF);
    rd_chk(8'h3D, 8'h1F);
    wr_reg(8'h3A, 8'hC3);
    rd_chk(8'h3A, 8'hC3);
    wr_reg(8'h40, 8'h01);
    wr_reg(8'h36, 8'h5A);
    rd_chk(8'h36, 8'h5A);
    wr_reg(8'h40, 8'h00);
    rd_chk(8'h36, 8'h00);
    rd_chk(8'h37, 8'h9F);
  endtask

  task automatic t_pass();
    // limits set but enable clear: everything passes, timing unchanged
    set_crop(0, 1'b0, 13'h0003, 13'h0004, 13'h0001, 13'h0001);
    set_crop(1, 1'b0, 13'h0002, 13'h0002, 13'h0002, 13'h0002);
    run_frame(W / 2 * H, W / 2 * H);
  endtask

  task automatic t_crop();
    set_crop(0, 1'b1, 13'h0001, 13'h0005, 13'h0001, 13'h0003);
    set_crop(1, 1'b1, 13'h0000, 13'h0007, 13'h0004, 13'h0005);
    run_frame(15, 16);
  endtask

  task automatic t_edges();
    // start beyond the line via the high bits; defaults keep one pixel
    set_crop(0, 1'b1, 13'h0100, 13'h0105, 13'h0000, 13'h0005);
    set_crop(1, 1'b1, 13'h0000, 13'h0000, 13'h0000, 13'h0000);
    run_frame(0, 1);
  endtask

  initial begin
    en = '{1'b0, 1'b0};
    n_fwd = '{0, 0};
    n_stb = 0;
    n_hs = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pass();
    t_crop();
    t_edges();
    complete_run();
  end
endmodule // tb_sfc_top
